// file: rtl/mal_top.sv
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "mal_defines.svh"
// Summary of operation
// R1: feature 04h with F9h means freeze-lock
// R2: F9h after read-native is plain set-max
// R3: frozen rejects all later set-max commands
// R4: opcode 37h is extended set-max
// R5: host precedes 37h with read-native-ext
// R6: accepted ext sets limit; beyond aborts
// R7: above 28-bit limit only 48-bit words update
// R8: within 28-bit limit both word groups update
// R9: abort ext on listed failure cases
// R10: second non-volatile ext aborts until reset
// R11: count bit 0 selects persistent limit
// R12: persistent request invalid in offset mode
// R13: host splits lba over current/previous bytes
// R14: limit returned, high bytes when select set
// R15: locked rejects all set-max but unlock, freeze
// R16: abort sets abort flag and error bit
// R17: reset clears frozen, locked, read tracking
module mal_top #(
	parameter logic [47:0] CAPACITY = 48'h0000_ffff_ffff
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq
);
	import mal_pkg::*;
	// ----------------------------------------
	// registers
	// ----------------------------------------
	mal_task_type task_r;
	mal_state_type state_r;
	mal_result_type result_r;
	logic [47:0] limit_r;
	logic [47:0] id48_r;
	logic [27:0] id28_r;
	logic [47:0] nv_limit_r;
	logic nv_valid_r;
	logic prev_native_r;
	logic prev_native_ext_r;
	logic frozen_r;
	logic locked_r;
	logic hpa_r;
	logic nv_used_r;
	logic offset_mode_r;
	logic ext_supported_r;
	logic high_byte_select_r;
	logic [47:0] access_lba_r;
	logic access_abort_r;
	logic [3:0] events_r;
	logic [3:0] mask_r;
	logic go;
	logic [3:0] ev_set;
	logic is_freeze;
	logic is_lock;
	logic is_unlock;
	logic is_ext;
	logic is_set_addr;
	logic is_native;
	logic is_native_ext;
	logic persist;
	logic [47:0] req_lba;
	logic abort;
	logic aw_hold_r;
	logic w_hold_r;
	logic [11:0] awaddr_r;
	logic [31:0] wdata_r;
	logic wr_fire;
	logic [31:0] rd_mux;
	mal_decide u_decide (
		.task_in(task_r),
		.prev_native(prev_native_r),
		.prev_native_ext(prev_native_ext_r),
		.frozen(frozen_r),
		.locked(locked_r),
		.hpa_set(hpa_r),
		.nv_used(nv_used_r),
		.offset_mode(offset_mode_r),
		.ext_supported(ext_supported_r),
		.capacity(CAPACITY),
		.is_freeze(is_freeze),
		.is_lock(is_lock),
		.is_unlock(is_unlock),
		.is_ext(is_ext),
		.is_set_addr(is_set_addr),
		.is_native(is_native),
		.is_native_ext(is_native_ext),
		.persist(persist),
		.req_lba(req_lba),
		.abort(abort)
	);
	// ----------------------------------------
	// axi4-lite write channel
	// ----------------------------------------
	// address and data are latched separately so either may come first
	// one write in flight: both halves stay blocked while the response waits
	assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
	assign wr_fire = aw_hold_r && w_hold_r;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 12'h000;
			wdata_r <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
			end
			if (wr_fire) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign s_axi_bresp = 2'b00;
	// command write starts execution only when idle; busy writes are dropped
	assign go = wr_fire && awaddr_r == `MAL_OFF_CMD && state_r == MAL_IDLE;
	// ----------------------------------------
	// taskfile capture
	// ----------------------------------------
	// writes during a command are dropped so execution sees stable inputs
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			task_r <= '0;
		end else if (wr_fire && state_r == MAL_IDLE) begin
			case (awaddr_r)
				`MAL_OFF_CMD: begin
					task_r.command <= wdata_r[7:0];
					task_r.feature <= wdata_r[15:8];
					task_r.count_cur <= wdata_r[23:16];
				end
				`MAL_OFF_LBA_LO: task_r.lba_cur <= wdata_r[23:0];
				`MAL_OFF_LBA_HI: task_r.lba_prev <= wdata_r[23:0];
				default: task_r <= task_r;
			endcase
		end
	end
	// ----------------------------------------
	// configuration
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			offset_mode_r <= 1'b0;
			ext_supported_r <= 1'b1;
			high_byte_select_r <= 1'b0;
			mask_r <= `MAL_RST_MASK;
			access_lba_r <= 48'h0000_0000_0000;
		end else if (wr_fire) begin
			case (awaddr_r)
				`MAL_OFF_CONFIG: begin
					offset_mode_r <= wdata_r[0];
					ext_supported_r <= wdata_r[1];
					high_byte_select_r <= wdata_r[2];
				end
				`MAL_OFF_MASK: mask_r <= wdata_r[3:0];
				`MAL_OFF_ACCESS: access_lba_r <= {wdata_r[15:0], access_lba_r[31:0]};
				`MAL_OFF_READBACK: access_lba_r <= {access_lba_r[47:32], wdata_r};
				default: mask_r <= mask_r;
			endcase
		end
	end
	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	// busy shows while executing; the result lands as it clears
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_r <= MAL_IDLE;
			result_r <= '{status: `MAL_RST_STATUS, error: 8'h00};
		end else begin
			case (state_r)
				MAL_IDLE: begin
					if (go) begin
						state_r <= MAL_EXEC;
						result_r.status <= 8'h80;
					end
				end
				MAL_EXEC: begin
					state_r <= MAL_DONE;
					result_r.error <= abort ? 8'h04 : 8'h00; // R16
					result_r.status <= abort ? 8'h41 : 8'h40; // R16
				end
				MAL_DONE: state_r <= MAL_IDLE;
				default: state_r <= MAL_IDLE;
			endcase
		end
	end
	// ----------------------------------------
	// protection state
	// ----------------------------------------
	// reset restores capacity; the persistent copy below only stands in for storage
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			frozen_r <= 1'b0; // R17
			locked_r <= 1'b0; // R17
			prev_native_r <= 1'b0; // R17
			prev_native_ext_r <= 1'b0; // R17
			hpa_r <= 1'b0;
			nv_used_r <= 1'b0;
			limit_r <= CAPACITY;
			id48_r <= CAPACITY;
			id28_r <= 28'hfff_ffff;
		end else if (state_r == MAL_EXEC) begin
			prev_native_r <= is_native;
			prev_native_ext_r <= is_native_ext;
			if (!abort) begin
				if (is_freeze) begin
					frozen_r <= 1'b1; // R3
					locked_r <= 1'b0;
				end
				if (is_lock) begin
					locked_r <= 1'b1;
				end
				if (is_unlock) begin
					locked_r <= 1'b0;
				end
				if (is_set_addr) begin
					hpa_r <= 1'b1;
				end
				if (is_ext) begin
					limit_r <= req_lba; // R6
					id48_r <= req_lba; // R7
					// above the 28-bit range the short identify words keep their value
					if (req_lba <= `MAL_LBA28_LIMIT) begin
						id28_r <= req_lba[27:0]; // R8
					end
					if (persist) begin
						nv_used_r <= 1'b1; // R10
					end
				end
			end
		end
	end
	// persistent copy kept outside the volatile reset path in a real drive
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			nv_limit_r <= 48'h0000_0000_0000;
			nv_valid_r <= 1'b0;
		end else if (state_r == MAL_EXEC && is_ext && !abort && persist) begin
			nv_limit_r <= req_lba; // R11
			nv_valid_r <= 1'b1;
		end
	end
	// ----------------------------------------
	// access check
	// ----------------------------------------
	// registered so the wide compare stays off the read path
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			access_abort_r <= 1'b0;
		end else begin
			access_abort_r <= access_lba_r > limit_r; // R6
		end
	end
	// ----------------------------------------
	// events and interrupt
	// ----------------------------------------
	assign ev_set[3] = access_abort_r;
	assign ev_set[2] = state_r == MAL_EXEC && abort;
	assign ev_set[1] = state_r == MAL_EXEC && !abort;
	assign ev_set[0] = state_r == MAL_EXEC && is_freeze && !abort;
	// a set in the cycle of a clear survives
	for (genvar gi = 0; gi < 4; gi++) begin : g_event
		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				events_r[gi] <= 1'b0;
			end else if (ev_set[gi]) begin
				events_r[gi] <= 1'b1;
			end else if (wr_fire && awaddr_r == `MAL_OFF_EVENTS && wdata_r[gi]) begin
				events_r[gi] <= 1'b0;
			end
		end
	end
	assign irq = |(events_r & mask_r);
	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------
	// unmapped addresses read as zero with an okay response
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (s_axi_araddr)
			`MAL_OFF_CMD: rd_mux = {8'h00, task_r.count_cur, task_r.feature, task_r.command};
			`MAL_OFF_LBA_LO: rd_mux = high_byte_select_r ? {8'h00, limit_r[47:24]}
				: {8'h00, limit_r[23:0]}; // R14
			`MAL_OFF_LBA_HI: rd_mux = {8'h00, task_r.lba_prev};
			`MAL_OFF_STATUS: rd_mux = {12'h000, nv_used_r, hpa_r, locked_r, frozen_r,
				result_r.error, result_r.status};
			`MAL_OFF_LIMIT_LO: rd_mux = limit_r[31:0];
			`MAL_OFF_LIMIT_HI: rd_mux = {16'h0000, limit_r[47:32]};
			`MAL_OFF_ID48_LO: rd_mux = id48_r[31:0];
			`MAL_OFF_ID48_HI: rd_mux = {16'h0000, id48_r[47:32]};
			`MAL_OFF_ID28: rd_mux = {4'h0, id28_r};
			`MAL_OFF_EVENTS: rd_mux = {28'h0000000, events_r};
			`MAL_OFF_MASK: rd_mux = {28'h0000000, mask_r};
			`MAL_OFF_CONFIG: rd_mux = {29'h0, high_byte_select_r, ext_supported_r, offset_mode_r};
			`MAL_OFF_ACCESS: rd_mux = {31'h0, access_abort_r};
			`MAL_OFF_READBACK: rd_mux = {15'h0, nv_valid_r, nv_limit_r[47:32]};
			default: rd_mux = 32'h0000_0000;
		endcase
	end
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	assign s_axi_rresp = 2'b00;
endmodule : mal_top

// file: rtl/mal_defines.svh
`ifndef MAL_DEFINES_SVH
`define MAL_DEFINES_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define MAL_CMD_SET_MAX 8'hf9
`define MAL_CMD_SET_MAX_EXT 8'h37
`define MAL_CMD_READ_NATIVE 8'hf8
`define MAL_CMD_READ_NATIVE_EXT 8'h27
`define MAL_FEAT_SET_ADDR 8'h00
`define MAL_FEAT_SET_PWD 8'h01
`define MAL_FEAT_LOCK 8'h02
`define MAL_FEAT_UNLOCK 8'h03
`define MAL_FEAT_FREEZE 8'h04
// ----------------------------------------
// bit positions and the 28-bit limit
// ----------------------------------------
`define MAL_ERR_ABORT_BIT 2
`define MAL_STS_ERR_BIT 0
`define MAL_STS_RDY_BIT 6
`define MAL_STS_BSY_BIT 7
`define MAL_PERSIST_BIT 0
`define MAL_LBA28_LIMIT 48'h0000_0fff_ffff
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define MAL_OFF_CMD 12'h000
`define MAL_OFF_LBA_LO 12'h004
`define MAL_OFF_LBA_HI 12'h008
`define MAL_OFF_STATUS 12'h00c
`define MAL_OFF_LIMIT_LO 12'h010
`define MAL_OFF_LIMIT_HI 12'h014
`define MAL_OFF_ID48_LO 12'h018
`define MAL_OFF_ID48_HI 12'h01c
`define MAL_OFF_ID28 12'h020
`define MAL_OFF_EVENTS 12'h024
`define MAL_OFF_MASK 12'h028
`define MAL_OFF_CONFIG 12'h02c
`define MAL_OFF_ACCESS 12'h030
`define MAL_OFF_READBACK 12'h034
// ----------------------------------------
// reset values
// ----------------------------------------
`define MAL_RST_STATUS 8'h40
`define MAL_RST_MASK 4'h0
`endif

// file: rtl/mal_pkg.sv
package mal_pkg;
	typedef struct packed {
		logic [7:0] command;
		logic [7:0] feature;
		logic [7:0] count_cur;
		logic [23:0] lba_cur;
		logic [23:0] lba_prev;
	} mal_task_type;
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] error;
	} mal_result_type;
	typedef enum logic [1:0] {
		MAL_IDLE = 2'b00,
		MAL_EXEC = 2'b01,
		MAL_DONE = 2'b11
	} mal_state_type;
endpackage : mal_pkg

// file: rtl/mal_decide.sv
`timescale 1ns/1ps
`include "mal_defines.svh"
module mal_decide (
	input mal_pkg::mal_task_type task_in,
	input logic prev_native,
	input logic prev_native_ext,
	input logic frozen,
	input logic locked,
	input logic hpa_set,
	input logic nv_used,
	input logic offset_mode,
	input logic ext_supported,
	input logic [47:0] capacity,
	output logic is_freeze,
	output logic is_lock,
	output logic is_unlock,
	output logic is_ext,
	output logic is_set_addr,
	output logic is_native,
	output logic is_native_ext,
	output logic persist,
	output logic [47:0] req_lba,
	output logic abort
);
	import mal_pkg::*;
	logic is_f9;
	logic is_sub;
	assign is_f9 = task_in.command == `MAL_CMD_SET_MAX;
	// a set-max right after read-native is the address form whatever the feature
	assign is_sub = is_f9 && !prev_native; // R2
	assign is_freeze = is_sub && task_in.feature == `MAL_FEAT_FREEZE; // R1
	assign is_lock = is_sub && task_in.feature == `MAL_FEAT_LOCK;
	assign is_unlock = is_sub && task_in.feature == `MAL_FEAT_UNLOCK;
	assign is_set_addr = is_f9 && (prev_native || (!is_freeze && !is_lock && !is_unlock
		&& task_in.feature != `MAL_FEAT_SET_PWD)); // R2
	assign is_ext = task_in.command == `MAL_CMD_SET_MAX_EXT; // R4
	assign is_native = task_in.command == `MAL_CMD_READ_NATIVE;
	assign is_native_ext = task_in.command == `MAL_CMD_READ_NATIVE_EXT;
	assign persist = task_in.count_cur[`MAL_PERSIST_BIT]; // R11
	assign req_lba = {task_in.lba_prev[23:16], task_in.lba_prev[15:8], task_in.lba_prev[7:0],
		task_in.lba_cur[23:16], task_in.lba_cur[15:8], task_in.lba_cur[7:0]}; // R13
	always_comb begin
		abort = 1'b0;
		if (is_f9) begin
			if (frozen) begin
				abort = 1'b1; // R3
			end else if (locked && !is_unlock && !is_freeze) begin
				abort = 1'b1; // R15
			end
		end else if (is_ext) begin
			// R9
			if (!ext_supported || req_lba > capacity || hpa_set || !prev_native_ext
				|| locked || frozen) begin
				abort = 1'b1;
			end else if (persist && nv_used) begin
				abort = 1'b1; // R10
			end else if (persist && offset_mode) begin
				abort = 1'b1; // R12
			end
		end
	end
endmodule : mal_decide

// file: tb/mal_chk_props.sv
`timescale 1ns/1ps
module mal_chk (
	input logic mclk,
	input logic rstn,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic s_axi_rvalid,
	input logic [1:0] s_axi_rresp,
	input logic s_axi_rready
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data not held");
	property p_bresp; s_axi_bvalid |-> s_axi_bresp == 2'h0; endproperty
	a_bresp: assert property (p_bresp) else $error("bad write response");
	property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rlat: assert property (p_rlat) else $error("read answer late");
	property p_blat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
	a_blat: assert property (p_blat) else $error("write answer late");
	property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_arblk: assert property (p_arblk) else $error("read taken while busy");
	property p_awblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_awblk: assert property (p_awblk) else $error("write taken while busy");
	property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_rdone: assert property (p_rdone) else $error("read answer repeated");
	property p_rresp; s_axi_rvalid |-> s_axi_rresp == 2'h0; endproperty
	a_rresp: assert property (p_rresp) else $error("bad read response");
endmodule : mal_chk

// file: tb/mal_host.sv
`timescale 1ns/1ps
module mal_host (
	input logic mclk,
	output logic [11:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [11:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic s_axi_rvalid,
	output logic s_axi_rready,
	output logic hang
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, hang} = '0;
		s_axi_wstrb = 4'hf;
	end
	// payloads are inverted once taken so stale data cannot pass for fresh
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic awh, wh, bh;
		int n;
		bh = 1'b0;
		n = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!bh && n < 100) begin
			@(negedge mclk);
			awh = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bh = s_axi_bvalid && s_axi_bready;
			n++;
			@(posedge mclk);
			if (awh) s_axi_awvalid <= 1'b0;
			if (awh) s_axi_awaddr <= ~a;
			if (wh) s_axi_wvalid <= 1'b0;
			if (wh) s_axi_wdata <= ~d;
			if (bh) s_axi_bready <= 1'b0;
		end
		if (!bh) hang = 1'b1;
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		logic arh, rh;
		int n;
		rh = 1'b0;
		n = 0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!rh && n < 100) begin
			@(negedge mclk);
			arh = s_axi_arvalid && s_axi_arready;
			rh = s_axi_rvalid && s_axi_rready;
			d = s_axi_rdata;
			n++;
			@(posedge mclk);
			if (arh) s_axi_arvalid <= 1'b0;
			if (arh) s_axi_araddr <= ~a;
			if (rh) s_axi_rready <= 1'b0;
		end
		if (!rh) hang = 1'b1;
	endtask : rd
endmodule : mal_host

// file: tb/tb_max_address_limit_cmds.sv
`timescale 1ns/1ps
module tb_max_address_limit_cmds;
	localparam logic [47:0] CAP = 48'h0000_ffff_ffff;
	localparam logic [31:0] ALL = 32'hffff_ffff;
	localparam logic [31:0] M16 = 32'h0000_ffff;
	localparam logic [31:0] AB = 32'h0000_0441;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, hang;
	int n_fail = 0;
	int n_checks = 0;
	always #5 mclk = ~mclk;
	mal_top #(.CAPACITY(CAP)) dut (.mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
	mal_host host (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .hang);
	// ----
	// helpers
	// ----
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		host.rd(a, d);
		chk($sformatf("reg %h", a), e, d & m);
	endtask : rc
	task automatic cirq(input logic e);
		@(negedge mclk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask : cirq
	task automatic do_reset();
		rstn <= 1'b0;
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
	endtask : do_reset
	// polls busy; a command that never finishes ends the run
	task automatic cmd(input logic [7:0] op, input logic [7:0] ft, input logic [7:0] cnt);
		logic [31:0] d;
		int n;
		n = 0;
		d = 32'h0000_0080;
		host.wr(12'h000, {8'h00, cnt, ft, op});
		while (d[7] && n < 20) begin
			host.rd(12'h00c, d);
			n++;
		end
		if (d[7]) begin
			n_fail++;
			final_report();
		end
	endtask : cmd
	task automatic ldlba(input logic [47:0] v);
		host.wr(12'h004, {8'h00, v[23:0]});
		host.wr(12'h008, {8'h00, v[47:24]});
	endtask : ldlba
	task automatic ext(input logic [7:0] cnt);
		cmd(8'h27, 8'h00, 8'h00);
		cmd(8'h37, 8'h00, cnt);
	endtask : ext
	// ----
	// scenarios
	// ----
	task automatic t_ext();
		logic [31:0] v28;
		ldlba(48'h0000_1234_5678);
		host.rd(12'h020, v28);
		ext(8'h00);
		rc(12'h00c, M16, 32'h0000_0040);
		rc(12'h018, ALL, 32'h1234_5678);
		rc(12'h020, ALL, v28);
		host.wr(12'h02c, 32'h0000_0006);
		rc(12'h004, 32'h00ff_ffff, 32'h0000_0012);
		host.wr(12'h02c, 32'h0000_0002);
		rc(12'h004, 32'h00ff_ffff, 32'h0034_5678);
		host.wr(12'h030, 32'h0000_0000);
		host.wr(12'h034, 32'h1234_5679);
		rc(12'h030, 32'h0000_0001, 32'h0000_0001);
		cirq(1'b0);
		host.wr(12'h028, 32'h0000_0008);
		cirq(1'b1);
		host.wr(12'h034, 32'h1234_5678);
		rc(12'h030, 32'h0000_0001, 32'h0000_0000);
		host.wr(12'h024, 32'h0000_0008);
		cirq(1'b0);
		$display("t_ext done");
	endtask : t_ext
	task automatic t_small();
		ldlba(48'h0000_00ab_cdef);
		ext(8'h00);
		rc(12'h020, ALL, 32'h00ab_cdef);
		rc(12'h018, ALL, 32'h00ab_cdef);
		$display("t_small done");
	endtask : t_small
	task automatic t_abort();
		cmd(8'h37, 8'h00, 8'h00);
		rc(12'h00c, M16, AB);
		ldlba(CAP + 48'h1);
		ext(8'h00);
		rc(12'h00c, M16, AB);
		ldlba(48'h0000_0000_1000);
		host.wr(12'h02c, 32'h0000_0000);
		ext(8'h00);
		rc(12'h00c, M16, AB);
		host.wr(12'h02c, 32'h0000_0003);
		ext(8'h01);
		rc(12'h00c, M16, AB);
		host.wr(12'h02c, 32'h0000_0002);
		ext(8'h01);
		rc(12'h00c, 32'h0008_ffff, 32'h0008_0040);
		rc(12'h034, 32'h0001_0000, 32'h0001_0000);
		ext(8'h01);
		rc(12'h00c, M16, AB);
		ext(8'h00);
		rc(12'h00c, M16, 32'h0000_0040);
		$display("t_abort done");
	endtask : t_abort
	task automatic t_freeze();
		do_reset();
		rc(12'h00c, 32'h000f_ffff, 32'h0000_0040);
		cmd(8'hf8, 8'h00, 8'h00);
		cmd(8'hf9, 8'h04, 8'h00);
		rc(12'h00c, 32'h0005_0000, 32'h0004_0000);
		ext(8'h00);
		rc(12'h00c, M16, AB);
		cmd(8'hf9, 8'h04, 8'h00);
		rc(12'h00c, 32'h0001_ffff, 32'h0001_0040);
		for (int f = 0; f < 4; f++) begin
			cmd(8'hf9, f[7:0], 8'h00);
			rc(12'h00c, M16, AB);
		end
		cmd(8'h27, 8'h00, 8'h00);
		do_reset();
		cmd(8'h37, 8'h00, 8'h00);
		rc(12'h00c, 32'h0001_ffff, AB);
		$display("t_freeze done");
	endtask : t_freeze
	task automatic t_lock();
		cmd(8'hf9, 8'h02, 8'h00);
		rc(12'h00c, 32'h0002_ffff, 32'h0002_0040);
		cmd(8'hf9, 8'h01, 8'h00);
		rc(12'h00c, M16, AB);
		cmd(8'hf9, 8'h00, 8'h00);
		rc(12'h00c, M16, AB);
		ext(8'h00);
		rc(12'h00c, M16, AB);
		cmd(8'hf9, 8'h03, 8'h00);
		rc(12'h00c, 32'h0002_ffff, 32'h0000_0040);
		cmd(8'hf9, 8'h02, 8'h00);
		cmd(8'hf9, 8'h04, 8'h00);
		rc(12'h00c, 32'h0001_ffff, 32'h0001_0040);
		rc(12'h024, 32'h0000_0007, 32'h0000_0007);
		$display("t_lock done");
	endtask : t_lock
	initial begin
		do_reset();
		t_ext();
		t_small();
		t_abort();
		t_freeze();
		t_lock();
		final_report();
	end
	always @(posedge hang) begin
		n_fail++;
		final_report();
	end
endmodule : tb_max_address_limit_cmds
bind mal_top mal_chk u_chk (.mclk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rresp);
